// ===== dv/pcso_checker.sv
// Port checker for the pad configuration block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module pcso_checker (
    // Clock, reset and bus.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    // Configuration and internal sources.
    input wire logic scan_active_i,
    input wire logic clock_func_i,
    input wire logic tx_envelope_i,
    input wire logic tx_active_i,
    input wire logic sam_data_i,
    input wire logic rx_envelope_i,
    input wire logic rx_active_i,
    input wire logic rx_bit_i,
    // Pads and observe pin.
    input wire logic [7:0] pad_in_i,
    input wire logic [7:0] pad_out_o,
    input wire logic [7:0] pad_oe_n_o,
    input wire logic scan_pads_released_o,
    input wire logic observe_pin_o,
    input wire logic observe_pin_oe_n_o,
    input wire logic fast_pad_switching_o
);
    import pcso_pkg::*;
    logic live, wr_ok, rd_acc, mapped, obs_z, obs_d;
    logic [7:0] en_s, val_s, sel_s, exp_oe, exp_out, rd_exp, src_v;
    logic [3:0] sel_m2, stab;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Bus decode; the four registers sit on aligned words 0x110 to 0x11C.
    assign wr_ok = psel_i && penable_i && pwrite_i && pstrb_i[0];
    assign rd_acc = psel_i && penable_i && !pwrite_i;
    assign mapped = paddr_i[11:4] == 8'h11 && paddr_i[1:0] == 2'b00;
    assign rd_exp = !mapped ? 8'h00 : paddr_i[3:2] == 2'b00 ? en_s :
        paddr_i[3:2] == 2'b01 ? val_s : sel_s;

    // Shadows follow completed strobed writes; the first edge after reset is skipped via live.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            live <= 1'b0;
            en_s <= 8'h00;
            val_s <= 8'h00;
            sel_s <= 8'h00;
        end else begin
            live <= 1'b1;
            if (wr_ok && paddr_i == ADDR_PAD_OUTPUT_ENABLE) begin
                en_s <= pwdata_i[7:0];
            end
            if (wr_ok && paddr_i == ADDR_PAD_OUTPUT_VALUE) begin
                val_s <= pwdata_i[7:0];
            end
            if (wr_ok && paddr_i == ADDR_SIGNAL_OUTPUT_SELECT) begin
                sel_s <= pwdata_i[7:0] & OBSERVE_PIN_RW_MASK;
            end
        end
    end

    // Counts edges since the pad levels moved, so reads past the synchroniser can be judged.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stab <= 4'h0;
        end else if (!$stable(pad_in_i)) begin
            stab <= 4'h0;
        end else if (stab != 4'hF) begin
            stab <= stab + 4'h1;
        end
    end

    // Expected pad drive; floating bits are merged high so their data is ignored.
    always_comb begin
        exp_oe = ~en_s;
        exp_oe[6] = 1'b0;
        if (scan_active_i) begin
            exp_oe[3:0] = 4'hF;
        end
        exp_out = val_s;
        if (!en_s[6]) begin
            exp_out[6] = clock_func_i;
        end
        exp_out = exp_out | exp_oe;
    end

    // Observe sources packed so that selector code minus two indexes them.
    assign src_v = {rx_bit_i, rx_active_i, rx_envelope_i, sam_data_i, tx_active_i,
        tx_envelope_i, 2'b10};
    assign sel_m2 = sel_s[3:0] - 4'h2;
    assign obs_z = sel_m2 > 4'h7;
    assign obs_d = src_v[sel_m2[2:0]];

    oe_map_a: assert property (live |-> pad_oe_n_o == $past(exp_oe))
        else $error("pad enables differ from register and scan setting");
    out_map_a: assert property (live |-> (pad_out_o | pad_oe_n_o) == $past(exp_out))
        else $error("pad drive differs from value register");
    scan_rel_a: assert property (scan_active_i ##1 scan_active_i |->
        scan_pads_released_o && pad_oe_n_o[3:0] == 4'hF) else $error("scan pads still driven");
    obs_oe_a: assert property (live |-> observe_pin_oe_n_o == $past(obs_z))
        else $error("observe pin enable wrong for selector");
    obs_dat_a: assert property (live && !observe_pin_oe_n_o |-> observe_pin_o == $past(obs_d))
        else $error("observe pin shows wrong source");
    fast_pad_a: assert property (live |-> fast_pad_switching_o == $past(sel_s[7]))
        else $error("pad speed not following register");
    rd_reg_a: assert property (rd_acc && paddr_i != ADDR_PAD_INPUT_LEVEL |->
        prdata_o == {24'h00_0000, rd_exp}) else $error("register read data wrong");
    in_lvl_a: assert property (rd_acc && paddr_i == ADDR_PAD_INPUT_LEVEL && stab > 4'h4 |->
        prdata_o == {24'h00_0000, pad_in_i}) else $error("input level read wrong");
endmodule
bind pcso_pad_config pcso_checker chk_u (
    .clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .scan_active_i, .clock_func_i, .tx_envelope_i, .tx_active_i, .sam_data_i,
    .rx_envelope_i, .rx_active_i, .rx_bit_i, .pad_in_i, .pad_out_o, .pad_oe_n_o,
    .scan_pads_released_o, .observe_pin_o, .observe_pin_oe_n_o, .fast_pad_switching_o
);
`default_nettype wire

// ===== dv/pcso_pad_partner.sv
// Model of the outside circuitry on the multipurpose pads and the observe pin.
`timescale 1ns/1ps
`default_nettype none
module pcso_pad_partner (
    // Clock for the floating-pin memory.
    input wire logic clk_i,
    // Device side.
    input wire logic [7:0] pad_out_i,
    input wire logic [7:0] pad_oe_n_i,
    input wire logic observe_pin_i,
    input wire logic observe_pin_oe_n_i,
    // Outside drivers, used only on released pads.
    input wire logic [7:0] ext_val_i,
    input wire logic [7:0] ext_drive_i,
    // Resolved levels.
    output logic [7:0] pad_level_o,
    output var logic observe_level_o
);
    logic obs_last;
    // Device drive wins where enabled; released pads show the outside level or the pull-up.
    assign pad_level_o = (~pad_oe_n_i & pad_out_i) | (pad_oe_n_i & (~ext_drive_i | ext_val_i));
    // The observe pin has no pull, so a floating pin shows the inverse of its last level.
    always_ff @(posedge clk_i) begin
        if (!observe_pin_oe_n_i) begin
            obs_last <= observe_pin_i;
        end
    end
    assign observe_level_o = observe_pin_oe_n_i ? ~obs_last : observe_pin_i;
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the pad configuration block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pcso_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [3:0] pstrb_i = 4'h0;
    logic scan_active_i = 1'b0;
    logic clock_func_i = 1'b0;
    logic [5:0] src = 6'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_drv = 8'h00;
    logic [31:0] prdata_o;
    logic [7:0] pad_in_i, pad_out_o, pad_oe_n_o;
    logic pready_o, pslverr_o, scan_pads_released_o, observe_pin_o, observe_pin_oe_n_o;
    logic fast_pad_switching_o, obs_lvl;
    logic [32:0] exp_q[$];
    int err_count = 0;
    int checks_done = 0;

    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;

    pcso_pad_config dut (
        .clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
        .prdata_o, .pready_o, .pslverr_o, .scan_active_i, .clock_func_i,
        .tx_envelope_i(src[0]), .tx_active_i(src[1]), .sam_data_i(src[2]),
        .rx_envelope_i(src[3]), .rx_active_i(src[4]), .rx_bit_i(src[5]), .pad_in_i,
        .pad_out_o, .pad_oe_n_o, .scan_pads_released_o, .observe_pin_o, .observe_pin_oe_n_o,
        .fast_pad_switching_o
    );
    pcso_pad_partner ext (
        .clk_i, .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o), .observe_pin_i(observe_pin_o),
        .observe_pin_oe_n_i(observe_pin_oe_n_o), .ext_val_i(ext_val), .ext_drive_i(ext_drv),
        .pad_level_o(pad_in_i), .observe_level_o(obs_lvl)
    );

    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; the request is held until pready is seen at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        int n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= {24'($urandom()), d};
        pstrb_i <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", 33'h0_0000_0000, 33'h0_0000_0001);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 8'h00, 4'h0);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Each completed read is matched against the oldest noted expectation.
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o && !pwrite_i) begin
            chk("read data", {pslverr_o, prdata_o}, exp_q.pop_front());
        end
    end

    // Cuts a hang short; the tests need well under 2,000 cycles.
    initial begin
        #50000;
        err_count++;
        close_out();
    end

    // Main sequence: reset values, pad ownership, then every selector code.
    initial begin
        logic [7:0] en, val, oe, out, lvl, r, sv;
        int seed;
        seed = $urandom(32'hbda3);
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(ADDR_PAD_OUTPUT_ENABLE, 33'h0_0000_0000);
        rd(ADDR_PAD_OUTPUT_VALUE, 33'h0_0000_0000);
        rd(ADDR_SIGNAL_OUTPUT_SELECT, 33'h0_0000_0000);
        apb(1'b1, 12'h120, 8'hFF, 4'h1);
        rd(12'h120, 33'h1_0000_0000);
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            en = 8'($urandom());
            val = 8'($urandom());
            ext_val <= 8'($urandom());
            ext_drv <= 8'($urandom());
            clock_func_i <= 1'($urandom());
            scan_active_i <= (k > 4);
            apb(1'b1, ADDR_PAD_OUTPUT_ENABLE, en, 4'h1);
            apb(1'b1, ADDR_PAD_OUTPUT_VALUE, val, 4'h1);
            apb(1'b1, ADDR_PAD_OUTPUT_ENABLE, ~en, 4'h0);
            apb(1'b1, ADDR_PAD_INPUT_LEVEL, ~val, 4'h1);
            repeat (4) @(posedge clk_i);
            oe = ~en;
            oe[6] = 1'b0;
            if (k > 4) oe[3:0] = 4'hF;
            out = val;
            if (!en[6]) out[6] = clock_func_i;
            lvl = (~oe & out) | (oe & (~ext_drv | ext_val));
            chk("pad enable", pad_oe_n_o, oe);
            chk("pad drive", pad_out_o | pad_oe_n_o, out | oe);
            chk("scan release", scan_pads_released_o, k > 4);
            rd(ADDR_PAD_OUTPUT_ENABLE, {25'h000_0000, en});
            rd(ADDR_PAD_INPUT_LEVEL, {25'h000_0000, lvl});
        end
        $display("test pads done");
        for (int s = 0; s < 16; s++) begin
            src <= 6'($urandom());
            r = {1'($urandom()), 3'b111, 4'(s)};
            apb(1'b1, ADDR_SIGNAL_OUTPUT_SELECT, r, 4'h1);
            repeat (3) @(posedge clk_i);
            sv = {src, 2'b10};
            chk("observe enable", observe_pin_oe_n_o, s < 2 || s > 9);
            if (s >= 2 && s <= 9) chk("observe pin", obs_lvl, sv[s-2]);
            chk("fast pads", fast_pad_switching_o, r[7]);
            rd(ADDR_SIGNAL_OUTPUT_SELECT, {25'h000_0000, r & 8'h8F});
        end
        $display("test observe done");
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("reset enable", pad_oe_n_o, 8'hFF);
        chk("reset speed", fast_pad_switching_o, 1'b0);
        sys_rst_i <= 1'b0;
        rd(ADDR_PAD_OUTPUT_ENABLE, 33'h0_0000_0000);
        rd(ADDR_SIGNAL_OUTPUT_SELECT, 33'h0_0000_0000);
        $display("test reset again done");
        repeat (2) @(posedge clk_i);
        close_out();
    end
endmodule
`default_nettype wire

// ===== verilog/pcso_obs_if.sv
// Interface carrying the observe selector, its sources and the resolved pin drive.
`timescale 1ns/1ps
`default_nettype none
interface pcso_obs_if;
    logic [3:0] sel;
    logic tx_envelope;
    logic tx_active;
    logic sam_data;
    logic rx_envelope;
    logic rx_active;
    logic rx_bit;
    logic drive;
    logic drive_en;

    // The register side supplies selector and sources and reads back the drive.
    modport regs (
        output sel, tx_envelope, tx_active, sam_data, rx_envelope, rx_active, rx_bit,
        input drive, drive_en
    );
    // The multiplexer resolves what the observe pin shows.
    modport mux (
        input sel, tx_envelope, tx_active, sam_data, rx_envelope, rx_active, rx_bit,
        output drive, drive_en
    );
endinterface
`default_nettype wire

// ===== verilog/pcso_observe_mux.sv
// Selector multiplexer that picks what the observe pin shows.
`timescale 1ns/1ps
`default_nettype none
module pcso_observe_mux (
    // Selector, sources and resolved drive.
    pcso_obs_if.mux obs
);
    import pcso_pkg::*;

    // Every code decides both the level and whether the pin is driven at all.
    always_comb begin
        obs.drive = 1'b0;
        obs.drive_en = 1'b1;
        case (obs.sel)
            PCSO_SEL_HIZ_0, PCSO_SEL_HIZ_1: begin
                obs.drive_en = 1'b0; // see R06
            end
            PCSO_SEL_LOW: begin
                obs.drive = 1'b0; // see R06
            end
            PCSO_SEL_HIGH: begin
                obs.drive = 1'b1; // see R06
            end
            PCSO_SEL_TX_ENV: begin
                obs.drive = obs.tx_envelope; // see R07
            end
            PCSO_SEL_TX_ACT: begin
                obs.drive = obs.tx_active; // see R07
            end
            PCSO_SEL_SAM: begin
                obs.drive = obs.sam_data; // see R08
            end
            PCSO_SEL_RX_ENV: begin
                // Only meaningful while receiving type A at the lowest rate.
                obs.drive = obs.rx_envelope; // see R09
            end
            PCSO_SEL_RX_ACT: begin
                obs.drive = obs.rx_active; // see R10
            end
            PCSO_SEL_RX_BIT: begin
                obs.drive = obs.rx_bit; // see R10
            end
            default: begin
                // Unused codes float the pin rather than show anything stray.
                obs.drive_en = 1'b0; // see R14
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== verilog/pcso_pad_config.sv
// Pad configuration and observe-pin block with its APB register slave.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R01: Enable bits 1 and 0 make the TDI and TDO pads drive their output-value bits.
// R02: With boundary scan active, enables for the four scan pads are ignored.
// R03: Output-value register holds one writable level per pad, signal-in down to TDO.
// R04: Input-level register is read-only and returns each pad's present level.
// R05: Pad-speed bit selects fast switching; cleared means normal speed.
// R06: Selector 0 and 1 float the observe pin, 2 drives low, 3 high.
// R07: Selector 4 shows transmit envelope, 5 shows transmitter active.
// R08: Selector 6 shows the secure module data signal.
// R09: Selector 7 shows receive envelope, meaningful only for type A at 106 kBd.
// R10: Selector 8 shows receiver active, 9 the recovered receive bit.
// R11: Selector sits in bits 3 to 0; bits 6 to 4 are reserved.
// R12: Output-enable register holds one enable per pad, same bit order.
// R13: Clock-out enable switches off the clock function; the value bit drives instead.
// R14: Selector codes A to F float the pin; reserved bits read zero.
// R15: A pad with its enable cleared stays an input, ignoring its value bit; here the clock pad drives the clock function instead.
module pcso_pad_config (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [pcso_pkg::APB_AW-1:0] paddr_i,
    input wire logic [pcso_pkg::APB_DW-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [pcso_pkg::APB_DW-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Device configuration and internal sources on this clock.
    input wire logic scan_active_i,
    input wire logic clock_func_i,
    input wire logic tx_envelope_i,
    input wire logic tx_active_i,
    input wire logic sam_data_i,
    input wire logic rx_envelope_i,
    input wire logic rx_active_i,
    input wire logic rx_bit_i,
    // Multipurpose pads, bit order signal-in down to TDO.
    input wire logic [pcso_pkg::PAD_NUM-1:0] pad_in_i,
    output logic [pcso_pkg::PAD_NUM-1:0] pad_out_o,
    output logic [pcso_pkg::PAD_NUM-1:0] pad_oe_n_o,
    output logic scan_pads_released_o,
    // Observe pin and pad speed.
    output logic observe_pin_o,
    output logic observe_pin_oe_n_o,
    output logic fast_pad_switching_o
);
    import pcso_pkg::*;

    // Software-visible state.
    logic [7:0] pad_output_enable;
    logic [7:0] pad_output_value;
    logic [7:0] signal_output_select;

    // Synchroniser; logic reads only stage two.
    logic [7:0] pad_sync_1;
    logic [7:0] pad_input_level;

    // Pad decision ahead of its register.
    logic [7:0] next_pad_drive;
    logic [7:0] next_pad_oe_n;

    // Bus decode and read path.
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic access_phase;
    logic wr_en;
    logic rd_en;
    logic addr_mapped;
    logic scan_cfg;

    // Observe selector connection to the multiplexer.
    pcso_obs_if obs_bus ();

    // Address match on a mapped word; the low two bits must be zero for an aligned access.
    // No partial decode, so no aliases.
    function automatic logic reg_hit(input logic [APB_AW-1:0] addr,
                                     input logic [APB_AW-1:0] target);
        reg_hit = (addr == target);
    endfunction

    // Applies the byte-lane strobe of lane zero to an 8-bit register.
    // Masked-off bits are stored as zero.
    function automatic logic [7:0] lane_merge(input logic [7:0] old_val,
                                              input logic [7:0] new_val,
                                              input logic strobe,
                                              input logic [7:0] keep_mask);
        if (strobe) begin
            lane_merge = new_val & keep_mask;
        end else begin
            lane_merge = old_val;
        end
    endfunction

    // The slave answers in the first access cycle, so no wait states are inserted.
    assign access_phase = psel_i & penable_i;
    assign pready_o = 1'b1;

    // Write and read strobes; data rides on lane zero.
    assign wr_en = access_phase & pwrite_i;
    assign rd_en = access_phase & ~pwrite_i;
    assign wr_data = pwdata_i[7:0];

    // Decode of the four words; anything else answers with an error.
    always_comb begin
        addr_mapped = reg_hit(paddr_i, ADDR_PAD_OUTPUT_ENABLE) |
                      reg_hit(paddr_i, ADDR_PAD_OUTPUT_VALUE) |
                      reg_hit(paddr_i, ADDR_PAD_INPUT_LEVEL) |
                      reg_hit(paddr_i, ADDR_SIGNAL_OUTPUT_SELECT);
    end

    // Error is flagged only during the access phase, as the bus expects.
    assign pslverr_o = access_phase & ~addr_mapped;

    // Output-enable register, one bit per pad.
    // A cleared lane-zero strobe changes nothing.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pad_output_enable <= RST_PAD_OUTPUT_ENABLE;
        end else if (wr_en && reg_hit(paddr_i, ADDR_PAD_OUTPUT_ENABLE)) begin
            pad_output_enable <= lane_merge(pad_output_enable, wr_data, pstrb_i[0],
                                            8'hFF); // see R12
        end
    end

    // Output-value register, one level per pad.
    // Released pads keep their value for later.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pad_output_value <= RST_PAD_OUTPUT_VALUE;
        end else if (wr_en && reg_hit(paddr_i, ADDR_PAD_OUTPUT_VALUE)) begin
            pad_output_value <= lane_merge(pad_output_value, wr_data, pstrb_i[0],
                                           8'hFF); // see R03
        end
    end

    // Signal-output register; reserved bits are never stored so they read zero.
    // One write sets both speed and selector.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            signal_output_select <= RST_SIGNAL_OUTPUT_SELECT;
        end else if (wr_en && reg_hit(paddr_i, ADDR_SIGNAL_OUTPUT_SELECT)) begin
            signal_output_select <= lane_merge(signal_output_select, wr_data, pstrb_i[0],
                                               OBSERVE_PIN_RW_MASK); // see R11
        end
    end

    // Pad levels come from outside the clock domain, so they pass two flip-flops.
    // The price is two cycles of read latency.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pad_sync_1 <= 8'h00;
            pad_input_level <= 8'h00;
        end else begin
            pad_sync_1 <= pad_in_i;
            pad_input_level <= pad_sync_1; // see R04
        end
    end

    // Scan configuration is a static level from the nonvolatile loader on this clock.
    assign scan_cfg = scan_active_i;

    // Read multiplexer; writes to the input-level word are accepted but change nothing.
    // Unmapped words fall through to zero.
    always_comb begin
        rd_data = 8'h00;
        if (reg_hit(paddr_i, ADDR_PAD_OUTPUT_ENABLE)) begin
            rd_data = pad_output_enable;
        end else if (reg_hit(paddr_i, ADDR_PAD_OUTPUT_VALUE)) begin
            rd_data = pad_output_value;
        end else if (reg_hit(paddr_i, ADDR_PAD_INPUT_LEVEL)) begin
            rd_data = pad_input_level; // see R04
        end else if (reg_hit(paddr_i, ADDR_SIGNAL_OUTPUT_SELECT)) begin
            rd_data = signal_output_select & OBSERVE_PIN_RW_MASK; // see R14
        end
    end

    // Read data is registered at the access edge so it is stable for the master.
    // Loaded at setup end, held to the next read.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= {24'h00_0000, rd_data};
        end
    end

    // Per-pad drive decision. Each pad drives its value bit only when enabled,
    // otherwise it is released and behaves as a plain input.
    // Clock and scan pads override plain enables.
    always_comb begin
        next_pad_drive = pad_output_value;
        next_pad_oe_n = ~pad_output_enable; // see R15

        // Low two scan pads drive their value bits when enabled.
        next_pad_oe_n[PAD_TDI] = ~pad_output_enable[PAD_TDI]; // see R01
        next_pad_oe_n[PAD_TDO] = ~pad_output_enable[PAD_TDO]; // see R01

        // The clock pad carries the clock function until its enable takes it over.
        if (!pad_output_enable[PAD_CLOCK_OUT]) begin
            next_pad_drive[PAD_CLOCK_OUT] = clock_func_i; // see R13
            next_pad_oe_n[PAD_CLOCK_OUT] = 1'b0;
        end

        // Scan owns its four pads while active; the enables here are then ignored.
        if (scan_cfg) begin
            next_pad_oe_n = next_pad_oe_n | SCAN_PAD_MASK; // see R02
            next_pad_drive = next_pad_drive & ~SCAN_PAD_MASK;
        end
    end

    // Pad outputs are registered so no decode glitch reaches a pin. The clock pad
    // therefore shows the clock function delayed by one cycle.
    // Reset releases every pad so nothing fights the board.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pad_out_o <= 8'h00;
            pad_oe_n_o <= 8'hFF;
        end else begin
            pad_out_o <= next_pad_drive;
            pad_oe_n_o <= next_pad_oe_n;
        end
    end

    // Tells the scan controller that it may drive its four pads.
    // Trails scan by one cycle, in step with the pads.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            scan_pads_released_o <= 1'b0;
        end else begin
            scan_pads_released_o <= scan_cfg; // see R02
        end
    end

    // Pad speed follows bit 7; faster edges cost peak supply current.
    // Reserved bits 6 to 4 drive nothing.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fast_pad_switching_o <= 1'b0;
        end else begin
            fast_pad_switching_o <= signal_output_select[FAST_PAD_BIT]; // see R05
        end
    end

    // Selector and sources toward the multiplexer.
    // Sources share this clock; no synchroniser.
    assign obs_bus.sel = signal_output_select[SEL_LSB +: SEL_W]; // see R11
    assign obs_bus.tx_envelope = tx_envelope_i;
    assign obs_bus.tx_active = tx_active_i;
    assign obs_bus.sam_data = sam_data_i;
    assign obs_bus.rx_envelope = rx_envelope_i;
    assign obs_bus.rx_active = rx_active_i;
    assign obs_bus.rx_bit = rx_bit_i;

    // Observe multiplexer.
    pcso_observe_mux u_mux (
        .obs(obs_bus)
    );

    // Observe pin registered; a floating pin also drives its data low.
    // Low data keeps a floating pin quiet inside.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            observe_pin_o <= 1'b0;
            observe_pin_oe_n_o <= 1'b1;
        end else begin
            observe_pin_o <= obs_bus.drive & obs_bus.drive_en; // see R06
            observe_pin_oe_n_o <= ~obs_bus.drive_en; // see R14
        end
    end

endmodule
`default_nettype wire

// ===== verilog/pcso_pkg.sv
// Package with register map, field layout, reset values and selector codes of the pad block.
package pcso_pkg;

    // Bus and pad widths.
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    localparam int PAD_NUM = 8;
    localparam int SEL_W = 4;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [7:0] IDX_PAD_OUTPUT_ENABLE = 8'h44;
    localparam logic [7:0] IDX_PAD_OUTPUT_VALUE = 8'h45;
    localparam logic [7:0] IDX_PAD_INPUT_LEVEL = 8'h46;
    localparam logic [7:0] IDX_SIGNAL_OUTPUT_SELECT = 8'h47;
    localparam logic [APB_AW-1:0] ADDR_PAD_OUTPUT_ENABLE = 12'h0110;
    localparam logic [APB_AW-1:0] ADDR_PAD_OUTPUT_VALUE = 12'h0114;
    localparam logic [APB_AW-1:0] ADDR_PAD_INPUT_LEVEL = 12'h0118;
    localparam logic [APB_AW-1:0] ADDR_SIGNAL_OUTPUT_SELECT = 12'h011C;

    // Pad bit positions, shared by enable, value and input-level registers.
    localparam int PAD_SIGNAL_IN = 7;
    localparam int PAD_CLOCK_OUT = 6;
    localparam int PAD_IFSEL_1 = 5;
    localparam int PAD_IFSEL_0 = 4;
    localparam int PAD_TCK = 3;
    localparam int PAD_TMS = 2;
    localparam int PAD_TDI = 1;
    localparam int PAD_TDO = 0;
    localparam logic [7:0] SCAN_PAD_MASK = 8'h0F;

    // Signal-output register fields.
    localparam int FAST_PAD_BIT = 7;
    localparam int SEL_LSB = 0;
    localparam logic [7:0] OBSERVE_PIN_RW_MASK = 8'h8F;

    // Reset values.
    localparam logic [7:0] RST_PAD_OUTPUT_ENABLE = 8'h00;
    localparam logic [7:0] RST_PAD_OUTPUT_VALUE = 8'h00;
    localparam logic [7:0] RST_SIGNAL_OUTPUT_SELECT = 8'h00;

    // Observe source selector codes.
    typedef enum logic [SEL_W-1:0] {
        PCSO_SEL_HIZ_0 = 4'h0,
        PCSO_SEL_HIZ_1 = 4'h1,
        PCSO_SEL_LOW = 4'h2,
        PCSO_SEL_HIGH = 4'h3,
        PCSO_SEL_TX_ENV = 4'h4,
        PCSO_SEL_TX_ACT = 4'h5,
        PCSO_SEL_SAM = 4'h6,
        PCSO_SEL_RX_ENV = 4'h7,
        PCSO_SEL_RX_ACT = 4'h8,
        PCSO_SEL_RX_BIT = 4'h9
    } pcso_sel_t;

endpackage
